// >>> design/pgfas_edge_rise.sv
module pgfas_edge_rise
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Raw asynchronous level and its rising edge
  input  wire logic level_in,
  output logic      rise_pulse
);

  logic sync1_reg;
  logic sync2_reg;
  logic last_reg;
  logic sync1_next;
  logic sync2_next;
  logic last_next;

  // ---------------------------------------------------------------
  // Two-stage synchroniser then edge detect
  // ---------------------------------------------------------------
  always_comb
  begin
    sync1_next = level_in;
    sync2_next = sync1_reg;
    last_next  = sync2_reg;
  end

  // Register stage
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg  <= 1'b0;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      last_reg  <= last_next;
    end
  end

  // Second stage is compared with its delayed copy in last_reg
  assign rise_pulse = sync2_reg & ~last_reg;

endmodule

// >>> design/pgfas_pkg.sv
package pgfas_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned BASE_DELAY_US   = 200;
  // Base step of the rising delay, cycles of clk_sys (200 us)
  localparam int unsigned BASE_DELAY_CYC  = (BASE_DELAY_US * (CLK_HZ / 1_000_000));
  localparam int unsigned BASE_CNT_W      = 14;
  localparam logic [3:0]  FALL_DELAY_SW   = 4'hf; // 16 switching cycles, count 0..15

  // Multiples of the base step for the seven delay settings
  localparam int unsigned MULT_W          = 8;

  // ---------------------------------------------------------------
  // Window arithmetic
  // ---------------------------------------------------------------
  localparam int unsigned VAL_W           = 16;
  localparam int unsigned PCT_W           = 6;
  localparam logic [5:0]  WIN_PCT_MIN     = 6'h05;
  localparam logic [5:0]  WIN_PCT_MAX     = 6'h28;
  localparam logic [5:0]  WIN_PCT_DEFAULT = 6'h0a;

  // ---------------------------------------------------------------
  // Addressing
  // ---------------------------------------------------------------
  localparam logic [3:0]  ADDR_UPPER      = 4'h4;  // 0100
  localparam logic [6:0]  GLOBAL_ADDR     = 7'h5a;
  localparam logic [2:0]  ADDR_LOW_OPEN   = 3'h7;
  localparam logic [2:0]  STRAP_OPEN      = 3'h6;  // Open or supply code
  localparam logic [2:0]  ADDR_RESET      = 3'h7;
  localparam logic [2:0]  DELAY_RESET     = 3'h6;

  // Filter states
  typedef enum logic [1:0]
  {
    PGFAS_BAD     = 2'b00,
    PGFAS_RISING  = 2'b01,
    PGFAS_GOOD    = 2'b10,
    PGFAS_FALLING = 2'b11
  } pgfas_state_t;

endpackage

// >>> design/pgfas_top.sv
// Notes on behaviour
// R01: Good-to-bad waits 16 switching cycles
// R02: Bad-to-good waits strap-selected delay, seven settings
// R03: Delay strap latched at power-on or run edges
// R04: Window half-width programmable from 5% to 40%
// R05: Window centred on margined reference
// R06: Address is 0100 plus strap-decoded bits
// R07: Also answer global 0x5A and rail-group address
// R08: Address strap latched at power-on or run edges
// R09: Grounded strap minimum delay, supply strap maximum
// R10: Strap codes give 000 to 101, open gives 111
// R11: Return inside window cancels pending change
module pgfas_top
(
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                sys_rst,
  // Switching clock enable, one pulse per switching cycle
  input  wire logic                sw_tick,
  // Output measurement and margined reference
  input  wire logic [15:0]         vout_meas,
  input  wire logic [15:0]         vref_margined,
  input  wire logic [5:0]          window_pct,
  input  wire logic                window_limit_strap,
  // Straps, already decoded from resistor to code
  input  wire logic [2:0]          good_delay_strap,
  input  wire logic [2:0]          address_strap,
  // Initialization triggers
  input  wire logic                master_run_input,
  input  wire logic                standby_run_input,
  input  wire logic                operation_on_bit,
  // Address match
  input  wire logic [6:0]          rx_addr,
  input  wire logic [6:0]          rail_group_address,
  output logic                     addr_match,
  output logic [6:0]               slave_addr,
  // Status
  output logic                     power_good_flag,
  output logic                     in_window
);

  // ---------------------------------------------------------------
  // Synchronised inputs and trigger edges
  // ---------------------------------------------------------------
  logic master_rise;
  logic standby_rise;
  logic on_rise;
  logic on_last_reg;
  logic on_last_next;
  logic [2:0] dstrap_s1_reg;
  logic [2:0] dstrap_s2_reg;
  logic [2:0] astrap_s1_reg;
  logic [2:0] astrap_s2_reg;
  logic       wlim_s1_reg;
  logic       wlim_s2_reg;

  pgfas_edge_rise u_master
  (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .level_in   (master_run_input),
    .rise_pulse (master_rise)
  );

  pgfas_edge_rise u_standby
  (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .level_in   (standby_run_input),
    .rise_pulse (standby_rise)
  );

  // ON bit comes from logic on this clock: no synchroniser
  assign on_last_next = operation_on_bit;
  assign on_rise      = operation_on_bit & ~on_last_reg;

  // Strap pins cross from the board, two flops each
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      on_last_reg   <= 1'b0;
      dstrap_s1_reg <= 3'h0;
      dstrap_s2_reg <= 3'h0;
      astrap_s1_reg <= 3'h0;
      astrap_s2_reg <= 3'h0;
      wlim_s1_reg   <= 1'b0;
      wlim_s2_reg   <= 1'b0;
    end
    else
    begin
      on_last_reg   <= on_last_next;
      dstrap_s1_reg <= good_delay_strap;
      dstrap_s2_reg <= dstrap_s1_reg;
      astrap_s1_reg <= address_strap;
      astrap_s2_reg <= astrap_s1_reg;
      wlim_s1_reg   <= window_limit_strap;
      wlim_s2_reg   <= wlim_s1_reg;
    end
  end

  // ---------------------------------------------------------------
  // Strap latching
  // ---------------------------------------------------------------
  // Power-on sample waits for the synchronisers to fill
  logic [1:0] boot_cnt_reg;
  logic [1:0] boot_cnt_next;
  logic       boot_sample;
  logic       strap_load;
  logic [2:0] delay_code_reg;
  logic [2:0] delay_code_next;
  logic [2:0] addr_low_reg;
  logic [2:0] addr_low_next;

  assign boot_sample = (boot_cnt_reg == 2'h2);
  assign strap_load  = boot_sample | master_rise | standby_rise | on_rise;

  always_comb
  begin
    boot_cnt_next   = (boot_cnt_reg == 2'h3) ? boot_cnt_reg : boot_cnt_reg + 2'h1;
    delay_code_next = delay_code_reg;
    addr_low_next   = addr_low_reg;
    if (strap_load)
    begin
      delay_code_next = dstrap_s2_reg;                                // [R03]
      // Codes 6 and 7 both mean open or tied high
      if (astrap_s2_reg >= pgfas_pkg::STRAP_OPEN)
        addr_low_next = pgfas_pkg::ADDR_LOW_OPEN;                     // [R10]
      else
        addr_low_next = astrap_s2_reg;                                // [R08]
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      boot_cnt_reg   <= 2'h0;
      delay_code_reg <= pgfas_pkg::DELAY_RESET;
      addr_low_reg   <= pgfas_pkg::ADDR_RESET;
    end
    else
    begin
      boot_cnt_reg   <= boot_cnt_next;
      delay_code_reg <= delay_code_next;
      addr_low_reg   <= addr_low_next;
    end
  end

  // ---------------------------------------------------------------
  // Address formation and matching
  // ---------------------------------------------------------------
  assign slave_addr = {pgfas_pkg::ADDR_UPPER, addr_low_reg};          // [R06]
  assign addr_match = (rx_addr == slave_addr)
                    | (rx_addr == pgfas_pkg::GLOBAL_ADDR)             // [R07]
                    | (rx_addr == rail_group_address);                // [R07]

  // ---------------------------------------------------------------
  // Window comparison
  // ---------------------------------------------------------------
  // Percent is clamped; supply-tied limit strap forces the default
  logic [5:0]  pct_eff;
  logic [21:0] half_prod;
  logic [15:0] half_w;
  logic [16:0] win_hi;
  logic [16:0] win_lo;

  always_comb
  begin
    if (wlim_s2_reg)
      pct_eff = pgfas_pkg::WIN_PCT_DEFAULT;
    else if (window_pct < pgfas_pkg::WIN_PCT_MIN)
      pct_eff = pgfas_pkg::WIN_PCT_MIN;                               // [R04]
    else if (window_pct > pgfas_pkg::WIN_PCT_MAX)
      pct_eff = pgfas_pkg::WIN_PCT_MAX;                               // [R04]
    else
      pct_eff = window_pct;
    // Divide by 100 approximated as *41/4096: under 0.1% error
    half_prod = 22'(vref_margined) * 22'(pct_eff);
    half_w    = 16'((28'(half_prod) * 28'd41) >> 12);
    win_hi    = {1'b0, vref_margined} + {1'b0, half_w};               // [R05]
    win_lo    = {1'b0, vref_margined} - {1'b0, half_w};               // [R05]
  end

  assign in_window = ({1'b0, vout_meas} <= win_hi)
                   & (win_lo[16] | ({1'b0, vout_meas} >= win_lo));

  // ---------------------------------------------------------------
  // Good/bad filter
  // ---------------------------------------------------------------
  logic [7:0] mult;
  always_comb
  begin
    case (delay_code_reg)
      3'h0:    mult = 8'h01;   // 200 us, grounded strap [R09]
      3'h1:    mult = 8'h02;   // 400 us [R02]
      3'h2:    mult = 8'h04;   // 800 us
      3'h3:    mult = 8'h08;   // 1.6 ms
      3'h4:    mult = 8'h10;   // 3.2 ms
      3'h5:    mult = 8'h20;   // 6.4 ms
      default: mult = 8'h80;   // 25.6 ms, open or supply [R09]
    endcase
  end

  pgfas_pkg::pgfas_state_t state_reg;
  pgfas_pkg::pgfas_state_t state_next;
  logic [13:0] base_cnt_reg;
  logic [13:0] base_cnt_next;
  logic [7:0]  step_cnt_reg;
  logic [7:0]  step_cnt_next;
  logic [3:0]  sw_cnt_reg;
  logic [3:0]  sw_cnt_next;
  logic        in_win_reg;
  logic        flag_reg;
  logic        flag_next;

  localparam logic [13:0] BASE_LAST = 14'(pgfas_pkg::BASE_DELAY_CYC - 1);

  // Next-state: counters only run in the pending states
  always_comb
  begin
    state_next    = state_reg;
    base_cnt_next = 14'h0000;
    step_cnt_next = 8'h00;
    sw_cnt_next   = 4'h0;
    flag_next     = flag_reg;
    case (state_reg)
      pgfas_pkg::PGFAS_BAD:
      begin
        if (in_win_reg)
          state_next = pgfas_pkg::PGFAS_RISING;
      end
      pgfas_pkg::PGFAS_RISING:
      begin
        base_cnt_next = base_cnt_reg;
        step_cnt_next = step_cnt_reg;
        if (!in_win_reg)
          state_next = pgfas_pkg::PGFAS_BAD;                          // [R11]
        else if (base_cnt_reg == BASE_LAST)
        begin
          base_cnt_next = 14'h0000;
          if (step_cnt_reg + 8'h01 == mult)
          begin
            state_next = pgfas_pkg::PGFAS_GOOD;
            flag_next  = 1'b1;                                        // [R02]
          end
          else
            step_cnt_next = step_cnt_reg + 8'h01;
        end
        else
          base_cnt_next = base_cnt_reg + 14'h0001;
      end
      pgfas_pkg::PGFAS_GOOD:
      begin
        if (!in_win_reg)
          state_next = pgfas_pkg::PGFAS_FALLING;
      end
      pgfas_pkg::PGFAS_FALLING:
      begin
        sw_cnt_next = sw_cnt_reg;
        if (in_win_reg)
          state_next = pgfas_pkg::PGFAS_GOOD;                         // [R11]
        else if (sw_tick)
        begin
          if (sw_cnt_reg == pgfas_pkg::FALL_DELAY_SW)
          begin
            state_next = pgfas_pkg::PGFAS_BAD;
            flag_next  = 1'b0;                                        // [R01]
          end
          else
            sw_cnt_next = sw_cnt_reg + 4'h1;                          // [R01]
        end
      end
      default:
      begin
        state_next = pgfas_pkg::PGFAS_BAD;
        flag_next  = 1'b0;
      end
    endcase
  end

  // Register stage; flag starts low after reset
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_reg    <= pgfas_pkg::PGFAS_BAD;
      base_cnt_reg <= 14'h0000;
      step_cnt_reg <= 8'h00;
      sw_cnt_reg   <= 4'h0;
      in_win_reg   <= 1'b0;
      flag_reg     <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      base_cnt_reg <= base_cnt_next;
      step_cnt_reg <= step_cnt_next;
      sw_cnt_reg   <= sw_cnt_next;
      in_win_reg   <= in_window;
      flag_reg     <= flag_next;
    end
  end

  assign power_good_flag = flag_reg;

endmodule

// >>> test/pgfas_sw_model.sv
module pgfas_sw_model
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Switching cycle strobe
  output logic      sw_tick
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] div_reg;

  // One strobe per four cycles keeps the sixteen-cycle fall short
  always_ff @(posedge clk_sys)
  begin
    div_reg <= sys_rst ? 2'h0 : div_reg + 2'h1;
  end

  assign sw_tick = (div_reg == 2'h3);
endmodule

// >>> test/pgfas_top_properties.sv
module pgfas_top_properties
(
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  // Stimulus seen at the ports
  input wire logic       sw_tick,
  input wire logic       master_run_input,
  input wire logic       standby_run_input,
  input wire logic       operation_on_bit,
  input wire logic [6:0] rx_addr,
  input wire logic [6:0] rail_group_address,
  // Outputs
  input wire logic       addr_match,
  input wire logic [6:0] slave_addr,
  input wire logic       power_good_flag,
  input wire logic       in_window
);
  logic [23:0] in_cnt_reg;
  logic [23:0] in_cnt_next;
  logic [5:0]  out_tick_reg;
  logic [5:0]  out_tick_next;
  logic [3:0]  age_reg;
  logic [3:0]  age_next;
  logic [2:0]  trig_d_reg;
  logic        trig_any;

  // Saturating counters; cleared in reset so no unknown lingers
  always_comb
  begin
    trig_any = |({operation_on_bit, standby_run_input, master_run_input} & ~trig_d_reg);
    in_cnt_next = (sys_rst | ~in_window) ? 24'h0 : in_cnt_reg + {23'h0, ~(&in_cnt_reg)};
    out_tick_next = (sys_rst | in_window) ? 6'h0
                  : out_tick_reg + {5'h0, sw_tick & ~(&out_tick_reg)};
    age_next = (sys_rst | trig_any) ? 4'h0 : age_reg + {3'h0, ~(&age_reg)};
  end

  // Helper registers
  always_ff @(posedge clk_sys)
  begin
    in_cnt_reg <= in_cnt_next;
    out_tick_reg <= out_tick_next;
    age_reg <= age_next;
    trig_d_reg <= {operation_on_bit, standby_run_input, master_run_input};
  end

  default clocking dflt @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence s_released;
    $fell(sys_rst);
  endsequence

  sequence s_long_out;
    !in_window && out_tick_reg >= 6'h14;
  endsequence

  a_reset_values: assert property (s_released |-> !power_good_flag && slave_addr == 7'h27)
    else $error("reset values wrong");
  a_addr_upper: assert property (slave_addr[6:3] == 4'h4)
    else $error("address upper nibble wrong");
  a_addr_low_code: assert property (slave_addr[2:0] != 3'h6)
    else $error("address low bits illegal");
  a_addr_hold: assert property ($changed(slave_addr) |-> age_reg <= 4'h6)
    else $error("address changed without trigger");
  a_match_global: assert property (rx_addr == 7'h5a |-> addr_match)
    else $error("global address missed");
  a_match_rail: assert property (rx_addr == rail_group_address |-> addr_match)
    else $error("rail group address missed");
  a_match_only: assert property (addr_match |-> rx_addr == slave_addr || rx_addr == 7'h5a
    || rx_addr == rail_group_address)
    else $error("match on foreign address");
  a_rise_delay: assert property ($rose(power_good_flag) |-> in_cnt_reg >= 24'h002706)
    else $error("flag rose too early");
  a_fall_delay: assert property ($fell(power_good_flag) |-> out_tick_reg >= 6'h10)
    else $error("flag fell too early");
  a_fall_bound: assert property (s_long_out |-> !power_good_flag)
    else $error("flag held too long");
endmodule

bind pgfas_top pgfas_top_properties pgfas_top_properties_inst
(
  .clk_sys, .sys_rst, .sw_tick, .master_run_input, .standby_run_input, .operation_on_bit,
  .rx_addr, .rail_group_address, .addr_match, .slave_addr, .power_good_flag, .in_window
);

// >>> test/tb_pgfas_top.sv
module tb_pgfas_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_sys, sys_rst, sw_tick, window_limit_strap, addr_match;
  logic        master_run_input, standby_run_input, operation_on_bit;
  logic        power_good_flag, in_window;
  logic [15:0] vout_meas, vref_margined;
  logic [5:0]  window_pct;
  logic [2:0]  good_delay_strap, address_strap;
  logic [6:0]  rx_addr, rail_group_address, slave_addr;
  int          error_cnt, comparisons;
  logic [7:0]  probe [5] = '{8'h47, 8'hb5, 8'h63, 8'h48, 8'h4e};
  logic [15:0] vr [5] = '{16'h03e8, 16'h03e8, 16'h03e8, 16'h0460, 16'h03e8};
  logic [15:0] vo [5] = '{16'h0460, 16'h0460, 16'h0410, 16'h0460, 16'h0460};
  logic [5:0]  pc [5] = '{6'h0a, 6'h28, 6'h01, 6'h0a, 6'h28};

  pgfas_sw_model pgfas_sw_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .sw_tick(sw_tick));

  pgfas_top pgfas_top_inst
  (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sw_tick(sw_tick), .vout_meas(vout_meas),
    .vref_margined(vref_margined), .window_pct(window_pct),
    .window_limit_strap(window_limit_strap), .good_delay_strap(good_delay_strap),
    .address_strap(address_strap), .master_run_input(master_run_input),
    .standby_run_input(standby_run_input), .operation_on_bit(operation_on_bit),
    .rx_addr(rx_addr), .rail_group_address(rail_group_address), .addr_match(addr_match),
    .slave_addr(slave_addr), .power_good_flag(power_good_flag), .in_window(in_window)
  );

  // 50 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic end_sim;
    if (error_cnt == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Bounded wait; a missed level is a mismatch and ends the run
  task automatic wait_flag(input logic exp, input int lim);
    for (int i = 0; i < lim && power_good_flag !== exp; i++)
      cyc(1);
    check({15'h0, power_good_flag}, {15'h0, exp});
    if (power_good_flag !== exp)
      end_sim();
  endtask

  // Inputs change only at the falling edge
  initial
  begin
    error_cnt = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    {master_run_input, standby_run_input, operation_on_bit, window_limit_strap} = 4'h0;
    {address_strap, good_delay_strap} = {3'h3, 3'h0};
    {vref_margined, vout_meas, window_pct} = {16'h03e8, 16'h0000, 6'h0a};
    {rx_addr, rail_group_address} = {7'h00, 7'h31};
    cyc(5);
    sys_rst = 1'b0;
    cyc(6);
    check({9'h0, slave_addr}, 16'h0023);
    foreach (probe[i])
    begin
      rx_addr = probe[i][7:1];
      cyc(1);
      check({15'h0, addr_match}, {15'h0, probe[i][0]});
    end
    address_strap = 3'h5;
    cyc(10);
    check({9'h0, slave_addr}, 16'h0023);
    // Every strap code, triggers taken in turn
    for (int c = 0; c < 8; c++)
    begin
      // Strap settles through its synchroniser before the trigger edge
      address_strap = 3'(c);
      cyc(3);
      {master_run_input, standby_run_input, operation_on_bit} = 3'h1 << (c % 3);
      cyc(4);
      {master_run_input, standby_run_input, operation_on_bit} = 3'h0;
      cyc(4);
      check({9'h0, slave_addr}, {9'h0, 4'h4, (c < 6) ? 3'(c) : 3'h7});
    end
    good_delay_strap = 3'h6;
    // Window width, clamp, centre tracking and strap override
    for (int i = 0; i < 5; i++)
    begin
      {vref_margined, vout_meas, window_pct, window_limit_strap} = {vr[i], vo[i], pc[i], i == 4};
      cyc(4);
      check({15'h0, in_window}, {15'h0, i > 0 && i < 4});
    end
    {vref_margined, window_pct, window_limit_strap} = {16'h03e8, 6'h0a, 1'b0};
    vout_meas = 16'h03e8;
    cyc(5000);
    vout_meas = 16'h0000;
    cyc(20);
    vout_meas = 16'h03e8;
    cyc(9000);
    check({15'h0, power_good_flag}, 16'h0000);
    wait_flag(1'b1, 1100);
    vout_meas = 16'h0000;
    cyc(40);
    check({15'h0, power_good_flag}, 16'h0001);
    wait_flag(1'b0, 60);
    vout_meas = 16'h03e8;
    wait_flag(1'b1, 10100);
    vout_meas = 16'h0000;
    cyc(40);
    vout_meas = 16'h03e8;
    cyc(100);
    check({15'h0, power_good_flag}, 16'h0001);
    // A newly latched delay code doubles the rising wait
    good_delay_strap = 3'h1;
    cyc(3);
    operation_on_bit = 1'b1;
    cyc(2);
    operation_on_bit = 1'b0;
    vout_meas = 16'h0000;
    wait_flag(1'b0, 100);
    vout_meas = 16'h03e8;
    cyc(19000);
    check({15'h0, power_good_flag}, 16'h0000);
    wait_flag(1'b1, 1100);
    end_sim();
  end
endmodule
